//--- rtl/spcs_pkg.sv
package spcs_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS   = 10;
    localparam int WORD_NS  = 160;
    localparam int WORD_DIV = WORD_NS / CLK_NS;
    localparam int DIV_W    = 5;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam int         CTL_RX_INV = 0;
    localparam int         CTL_TX_INV = 1;
    localparam int         CTL_BYPASS = 2;
    localparam int         CTL_HALF   = 3;
    localparam int         CTL_AUTO   = 4;
    localparam int         CTL_W      = 5;
    localparam logic [4:0] CTRL_RST   = 5'h10;
    localparam int         ST_LOCK = 0;
    localparam int         ST_RD   = 1;
    localparam int         ST_CERR = 2;
    localparam int         ST_OVF  = 3;
    localparam int         ST_OFF  = 4;

    // ----------------------------------------
    // Line code
    // ----------------------------------------
    localparam int         SYM_W    = 10;
    localparam int         HIST_TOP = 19;
    localparam logic [3:0] OFF_MAX  = 4'h9;
    localparam logic [6:0] COMMA    = 7'h1F;
    localparam logic [5:0] K28_6    = 6'h0F;
    localparam logic [5:0] D7_6     = 6'h38;
    localparam logic [3:0] A7_4     = 4'h7;
    localparam logic [3:0] D3_4     = 4'hC;
    localparam logic [7:0] SKIP_BYTE = 8'h1C;
    localparam logic [5:0] ENC6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] ENC4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------
    localparam int         FIFO_AW = 3;
    localparam logic [3:0] FIFO_N  = 4'h8;
    localparam logic [3:0] CTC_HI  = 4'h6;
    localparam logic [3:0] CTC_LO  = 4'h2;

    typedef struct packed {
        logic [19:0] data;
        logic [1:0]  k;
        logic [1:0]  err;
    } spcs_rx_t;

    typedef struct packed {
        logic [19:0] data;
        logic [1:0]  k;
    } spcs_tx_t;

    typedef struct packed {
        logic [9:0] data;
        logic       k;
        logic       err;
    } spcs_ent_t;

    typedef enum logic [1:0] {
        ALN_SEARCH = 2'b01,
        ALN_LOCK   = 2'b10
    } spcs_aln_t;

endpackage

//--- rtl/spcs_channel.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module spcs_channel (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    input  wire logic                 ser_rx_clk,
    input  wire logic [9:0]           ser_rx_word,
    output logic [9:0]                ser_tx_word,
    output logic                      tx_clk_out,
    output logic                      rx_clk_out,
    output spcs_pkg::spcs_rx_t        fab_rx,
    output logic                      fab_rx_valid,
    input  wire spcs_pkg::spcs_tx_t   fab_tx,
    output logic                      fab_tx_take,
    input  wire logic                 bitslip
);
    import spcs_pkg::*;

    // ----------------------------------------
    // Code functions
    // ----------------------------------------
    function automatic logic [10:0] enc8b(input logic [7:0] d, input logic k,
                                          input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic       r;
        logic       a7;
        s6 = (k && d[4:0] == 5'h1C) ? K28_6 : ENC6[d[4:0]];
        if (rd && ($countones(s6) != 3 || s6 == D7_6)) begin
            s6 = ~s6;
        end
        r  = rd ^ ($countones(s6) != 3);
        a7 = k || (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
               || (r && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E));
        s4 = (d[7:5] == 3'h7 && a7) ? A7_4 : ENC4[d[7:5]];
        // K28 pairs its balanced 4b codes with the 6b disparity
        if (k && d[4:0] == 5'h1C && !r && $countones(s4) == 2 && s4 != D3_4) begin
            s4 = ~s4;
        end
        if (r && ($countones(s4) != 2 || s4 == D3_4)) begin
            s4 = ~s4;
        end
        r = r ^ ($countones(s4) != 2);
        enc8b = {r, s6, s4};
    endfunction

    // Returns {rd_out, err, k, byte}
    function automatic logic [10:0] dec10(input logic [9:0] c, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic       h6;
        logic       h4;
        logic [4:0] d5;
        logic [2:0] d3;
        logic       k28;
        logic       kx;
        logic       bad;
        int         n;
        s6 = c[9:4];
        s4 = c[3:0];
        // Undo the K28 swap of balanced 4b codes
        if (s6 == ~K28_6 && $countones(s4) == 2) begin
            s4 = ~s4;
        end
        h6 = 1'b0;
        h4 = 1'b0;
        d5 = 5'h00;
        d3 = 3'h0;
        for (int i = 0; i < 32; i++) begin
            if (s6 == ENC6[i] || (s6 == ~ENC6[i] &&
                ($countones(ENC6[i]) != 3 || ENC6[i] == D7_6))) begin
                h6 = 1'b1;
                d5 = 5'(i);
            end
        end
        k28 = (s6 == K28_6) || (s6 == ~K28_6);
        if (k28) begin
            h6 = 1'b1;
            d5 = 5'h1C;
        end
        for (int j = 0; j < 8; j++) begin
            if (s4 == ENC4[j] || (s4 == ~ENC4[j] &&
                ($countones(ENC4[j]) != 2 || ENC4[j] == D3_4))) begin
                h4 = 1'b1;
                d3 = 3'(j);
            end
        end
        if (s4 == A7_4 || s4 == ~A7_4) begin
            h4 = 1'b1;
            d3 = 3'h7;
        end
        kx = (s4 == A7_4 || s4 == ~A7_4) &&
             (d5 == 5'h17 || d5 == 5'h1B || d5 == 5'h1D || d5 == 5'h1E);
        n   = $countones(c);
        bad = n < 4 || n > 6 || (n == 6 && rd) || (n == 4 && !rd);
        dec10 = {(n == 6) ? 1'b1 : (n == 4) ? 1'b0 : rd,
                 !h6 || !h4 || bad, k28 || kx, d3, d5};
    endfunction

    function automatic logic [9:0] sel(input logic [19:0] h, input logic [3:0] o);
        sel = h[HIST_TOP - int'(o) -: SYM_W];
    endfunction

    function automatic logic is_skip(input spcs_ent_t e);
        is_skip = e.k && e.data[7:0] == SKIP_BYTE;
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [4:0]  ctrl;
    logic        code_err;
    logic        fifo_ovf;
    logic        rx_rd;
    logic [3:0]  off;
    spcs_aln_t   aln;
    logic        stat_clr;
    logic        set_cerr;
    logic        set_ovf;

    assign stat_clr = reg_wr && reg_addr == ADDR_STAT;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= CTRL_RST;
        end else if (reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl <= reg_wdata[CTL_W-1:0];
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            code_err <= 1'b0;
            fifo_ovf <= 1'b0;
        end else begin
            code_err <= set_cerr || (code_err && !(stat_clr && reg_wdata[ST_CERR]));
            fifo_ovf <= set_ovf || (fifo_ovf && !(stat_clr && reg_wdata[ST_OVF]));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL: reg_rdata <= {27'h0, ctrl};
                ADDR_STAT: reg_rdata <= {24'h0, off, fifo_ovf, code_err, rx_rd,
                                         aln == ALN_LOCK};
                default:   reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Receive sampling
    // ----------------------------------------
    // Link clock is slow against clk, so edges are found by sampling
    logic       rxc_s1;
    logic       rxc_s2;
    logic       rxc_s3;
    logic [9:0] rxd_s1;
    logic [9:0] rxd_s2;
    logic       rx_tick;
    logic       dec_go;
    logic [19:0] hist;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxc_s1 <= 1'b0;
            rxc_s2 <= 1'b0;
            rxc_s3 <= 1'b0;
            rxd_s1 <= 10'h000;
            rxd_s2 <= 10'h000;
        end else begin
            rxc_s1 <= ser_rx_clk;
            rxc_s2 <= rxc_s1;
            rxc_s3 <= rxc_s2;
            rxd_s1 <= ser_rx_word;
            rxd_s2 <= rxd_s1;
        end
    end

    assign rx_tick    = rxc_s2 && !rxc_s3;
    assign rx_clk_out = rxc_s3;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist   <= 20'h00000;
            dec_go <= 1'b0;
        end else begin
            dec_go <= rx_tick;
            if (rx_tick) begin
                hist <= {hist[9:0], rxd_s2 ^ {SYM_W{ctrl[CTL_RX_INV]}}};
            end
        end
    end

    // ----------------------------------------
    // Word alignment
    // ----------------------------------------
    logic       comma_hit;
    logic [3:0] comma_off;

    always_comb begin
        logic [9:0] w;
        w         = 10'h000;
        comma_hit = 1'b0;
        comma_off = 4'h0;
        for (int o = SYM_W - 1; o >= 0; o--) begin
            w = sel(hist, 4'(o));
            if (w[9:3] == COMMA || w[9:3] == ~COMMA) begin
                comma_hit = 1'b1;
                comma_off = 4'(o);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aln <= ALN_SEARCH;
            off <= 4'h0;
        end else if (bitslip) begin
            off <= (off == OFF_MAX) ? 4'h0 : off + 4'h1;
            aln <= ALN_LOCK;
        end else begin
            case (aln)
                ALN_SEARCH: begin
                    if (dec_go && ctrl[CTL_AUTO] && comma_hit) begin
                        off <= comma_off;
                        aln <= ALN_LOCK;
                    end
                end
                ALN_LOCK: begin
                    // Search again only when software re-arms auto mode
                    if (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTL_AUTO] &&
                        !ctrl[CTL_AUTO]) begin
                        aln <= ALN_SEARCH;
                    end
                end
                default: aln <= ALN_SEARCH;
            endcase
        end
    end

    // ----------------------------------------
    // Decode and drift compensation
    // ----------------------------------------
    logic [9:0]  word_al;
    logic [10:0] dec;
    spcs_ent_t   ent_in;
    logic        push;
    logic        pop;
    logic        insert;
    logic        fab_tick;
    spcs_ent_t   mem [8];
    logic [2:0]  wptr;
    logic [2:0]  rptr;
    logic [3:0]  cnt;
    spcs_ent_t   head;

    assign word_al = sel(hist, off);
    assign dec     = dec10(word_al, rx_rd);
    assign ent_in  = ctrl[CTL_BYPASS] ? spcs_ent_t'{data: word_al, k: 1'b0, err: 1'b0}
                                      : spcs_ent_t'{data: {2'b00, dec[7:0]}, k: dec[8],
                                                    err: dec[9]};
    // Drop a skip when nearly full
    assign push     = dec_go && !(!ctrl[CTL_BYPASS] && cnt >= CTC_HI && is_skip(ent_in));
    assign set_ovf  = push && cnt == FIFO_N;
    assign set_cerr = dec_go && !ctrl[CTL_BYPASS] && dec[9];
    assign head     = mem[rptr];
    // Repeat a skip when nearly empty
    assign insert   = !ctrl[CTL_BYPASS] && cnt <= CTC_LO && is_skip(head);
    assign pop      = fab_tick && cnt != 4'h0 && !insert;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_rd <= 1'b0;
        end else if (dec_go && !ctrl[CTL_BYPASS]) begin
            rx_rd <= dec[10];
        end
    end

    // Storage needs no reset: count gates every read
    always_ff @(posedge clk) begin
        if (push && cnt != FIFO_N) begin
            mem[wptr] <= ent_in;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr <= 3'h0;
            rptr <= 3'h0;
            cnt  <= 4'h0;
        end else begin
            if (push && cnt != FIFO_N) begin
                wptr <= wptr + 3'h1;
            end
            if (pop) begin
                rptr <= rptr + 3'h1;
            end
            cnt <= cnt + 4'(push && cnt != FIFO_N) - 4'(pop);
        end
    end

    // ----------------------------------------
    // Fabric word rate
    // ----------------------------------------
    logic [DIV_W-1:0] div;

    assign fab_tick = div == DIV_W'(WORD_DIV - 1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div        <= '0;
            tx_clk_out <= 1'b0;
        end else begin
            div        <= fab_tick ? '0 : div + DIV_W'(1);
            tx_clk_out <= div < DIV_W'(WORD_DIV / 2);
        end
    end

    // ----------------------------------------
    // Receive fabric side
    // ----------------------------------------
    logic      rx_ph;
    spcs_ent_t rx_hold;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_ph        <= 1'b0;
            rx_hold      <= '0;
            fab_rx       <= '0;
            fab_rx_valid <= 1'b0;
        end else begin
            fab_rx_valid <= 1'b0;
            if (fab_tick && cnt != 4'h0) begin
                if (!ctrl[CTL_HALF]) begin
                    fab_rx       <= '{data: {10'h000, head.data}, k: {1'b0, head.k},
                                      err: {1'b0, head.err}};
                    fab_rx_valid <= 1'b1;
                end else if (!rx_ph) begin
                    rx_hold <= head;
                    rx_ph   <= 1'b1;
                end else begin
                    fab_rx       <= '{data: {head.data, rx_hold.data},
                                      k: {head.k, rx_hold.k},
                                      err: {head.err, rx_hold.err}};
                    fab_rx_valid <= 1'b1;
                    rx_ph        <= 1'b0;
                end
            end
            if (!ctrl[CTL_HALF]) begin
                rx_ph <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    logic        tx_ph;
    logic        tx_rd;
    logic [9:0]  tx_hi;
    logic        tx_hik;
    logic [9:0]  tx_raw;
    logic        tx_k;
    logic        tx_now;
    logic [10:0] enc;

    assign tx_now = fab_tick && (!ctrl[CTL_HALF] || !tx_ph);
    assign tx_raw = (ctrl[CTL_HALF] && tx_ph) ? tx_hi : fab_tx.data[9:0];
    assign tx_k   = (ctrl[CTL_HALF] && tx_ph) ? tx_hik : fab_tx.k[0];
    assign enc    = enc8b(tx_raw[7:0], tx_k, tx_rd);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ph       <= 1'b0;
            tx_rd       <= 1'b0;
            tx_hi       <= 10'h000;
            tx_hik      <= 1'b0;
            fab_tx_take <= 1'b0;
            ser_tx_word <= 10'h000;
        end else begin
            fab_tx_take <= tx_now;
            if (tx_now) begin
                tx_hi  <= fab_tx.data[19:10];
                tx_hik <= fab_tx.k[1];
            end
            if (fab_tick) begin
                tx_ph <= ctrl[CTL_HALF] && !tx_ph;
                if (ctrl[CTL_BYPASS]) begin
                    ser_tx_word <= tx_raw ^ {SYM_W{ctrl[CTL_TX_INV]}};
                end else begin
                    tx_rd       <= enc[10];
                    ser_tx_word <= enc[9:0] ^ {SYM_W{ctrl[CTL_TX_INV]}};
                end
            end
        end
    end

endmodule // spcs_channel

`default_nettype wire

//--- test/spcs_channel_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checks
// ----------------------------------------
module spcs_channel_asserts (
    input wire logic               clk,
    input wire logic               arst_n,
    input wire logic               ser_rx_clk,
    input wire logic [9:0]         ser_tx_word,
    input wire logic               tx_clk_out,
    input wire logic               rx_clk_out,
    input wire spcs_pkg::spcs_rx_t fab_rx,
    input wire logic               fab_rx_valid,
    input wire logic               fab_tx_take
);
    import spcs_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_take_pulse; fab_tx_take |=> !fab_tx_take; endproperty
    a_take_pulse: assert property (p_take_pulse)
        else $error("take pulse longer than one cycle");
    property p_take_rise; fab_tx_take |=> $rose(tx_clk_out); endproperty
    a_take_rise: assert property (p_take_rise)
        else $error("take away from fabric clock rise");
    property p_word_tick; $changed(ser_tx_word) |=> $rose(tx_clk_out); endproperty
    a_word_tick: assert property (p_word_tick)
        else $error("serializer word changed off its tick");
    property p_txclk; $rose(tx_clk_out) |-> tx_clk_out[*8] ##1 !tx_clk_out; endproperty
    a_txclk: assert property (p_txclk)
        else $error("transmit clock high time wrong");
    property p_valid_gap; fab_rx_valid |=> !fab_rx_valid[*8]; endproperty
    a_valid_gap: assert property (p_valid_gap)
        else $error("receive valid too close");
    property p_rx_hold; !fab_rx_valid |-> $stable(fab_rx); endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("receive data moved without valid");
    property p_valid_rise; fab_rx_valid |=> $rose(tx_clk_out); endproperty
    a_valid_rise: assert property (p_valid_rise)
        else $error("receive valid off fabric clock rise");
    property p_rxclk; $rose(ser_rx_clk) |-> ##[1:4] rx_clk_out; endproperty
    a_rxclk: assert property (p_rxclk)
        else $error("recovered clock not forwarded");
endmodule // spcs_channel_asserts

`default_nettype wire

//--- test/spcs_fab_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Fabric user logic
// ----------------------------------------
module spcs_fab_model (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               half,
    input  wire logic               use_fixed,
    input  wire spcs_pkg::spcs_tx_t fixed,
    input  wire logic               clr,
    input  wire logic               fab_tx_take,
    input  wire spcs_pkg::spcs_rx_t fab_rx,
    input  wire logic               fab_rx_valid,
    output var spcs_pkg::spcs_tx_t  fab_tx,
    output var int                  good,
    output var int                  bad
);
    import spcs_pkg::*;
    int         idx;
    logic       seen_k = 1'b0;
    logic       primed = 1'b0;
    logic [7:0] last   = 8'h00;

    // Comma every eighth word so the receiver can align
    function automatic logic [9:0] word_of(input int i);
        word_of = (i % 8 == 0) ? 10'h0BC : {2'b00, i[7:0]};
    endfunction

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idx <= 0;
        end else if (fab_tx_take) begin
            idx <= idx + (half ? 2 : 1);
        end
    end

    // Held until taken, never earlier
    always_comb begin
        if (use_fixed) begin
            fab_tx = fixed;
        end else begin
            fab_tx.data = {word_of(idx + 1), word_of(idx)};
            fab_tx.k    = {((idx + 1) % 8 == 0), (idx % 8 == 0)};
        end
    end

    task automatic judge(input logic [7:0] b, input logic k, input logic e);
        if (!primed) begin
            primed = 1'b1;
        end else if (e !== 1'b0) begin
            bad++;
        end else if (!k) begin
            if (seen_k ? (b[2:0] == 3'h1) : (b == last + 8'h01)) good++;
            else bad++;
        end
        seen_k = k;
        last   = b;
    endtask

    always @(posedge clk) begin
        if (clr) begin
            good   = 0;
            bad    = 0;
            primed = 1'b0;
        end else if (fab_rx_valid === 1'b1) begin
            judge(fab_rx.data[7:0], fab_rx.k[0], fab_rx.err[0]);
            if (half) judge(fab_rx.data[17:10], fab_rx.k[1], fab_rx.err[1]);
        end
    end
endmodule // spcs_fab_model

`default_nettype wire

//--- test/spcs_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module spcs_channel_tb_top;
    import spcs_pkg::*;
    logic        clk;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        ser_rx_clk;
    logic [9:0]  ser_rx_word = 10'h000;
    logic [9:0]  ser_tx_word;
    logic        tx_clk_out;
    logic        rx_clk_out;
    spcs_rx_t    fab_rx;
    logic        fab_rx_valid;
    spcs_tx_t    fab_tx;
    logic        fab_tx_take;
    logic        bitslip = 1'b0;
    logic        half = 1'b0;
    logic        use_fixed = 1'b0;
    spcs_tx_t    fixed = '0;
    logic        clr = 1'b0;
    logic        corrupt = 1'b0;
    int          good;
    int          bad;
    int          err_total = 0;
    int          num_checks = 0;
    int          cyc = 0;

    // ----------------------------------------
    // Clocks and loopback
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Odd offset keeps link edges off the system edges
    initial begin
        ser_rx_clk = 1'b0;
        #3.3;
        forever #80 ser_rx_clk = ~ser_rx_clk;
    end
    always @(negedge ser_rx_clk) ser_rx_word <= corrupt ? 10'h000 : ser_tx_word;

    spcs_channel i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser_rx_clk(ser_rx_clk),
        .ser_rx_word(ser_rx_word), .ser_tx_word(ser_tx_word), .tx_clk_out(tx_clk_out),
        .rx_clk_out(rx_clk_out), .fab_rx(fab_rx), .fab_rx_valid(fab_rx_valid),
        .fab_tx(fab_tx), .fab_tx_take(fab_tx_take), .bitslip(bitslip));
    spcs_fab_model i_fab (.clk(clk), .arst_n(arst_n), .half(half), .use_fixed(use_fixed),
        .fixed(fixed), .clr(clr), .fab_tx_take(fab_tx_take), .fab_rx(fab_rx),
        .fab_rx_valid(fab_rx_valid), .fab_tx(fab_tx), .good(good), .bad(bad));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(what, reg_rdata & m, exp);
    endtask
    task automatic words(input int n);
        repeat (n * 16) @(posedge clk);
    endtask
    task automatic wait_take;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (fab_tx_take === 1'b1) break;
        end
        chk("take", {31'h0, fab_tx_take}, 32'h1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdchk("ctrl_rst", ADDR_CTRL, 32'hFFFFFFFF, {27'h0, CTRL_RST});
        rdchk("unmapped", 4'h8, 32'hFFFFFFFF, 32'h0);
        wr(4'h8, 32'hFFFFFFFF);
        rdchk("ctrl_keep", ADDR_CTRL, 32'hFFFFFFFF, {27'h0, CTRL_RST});
        wr(ADDR_CTRL, 32'hFFFFFFFF);
        rdchk("ctrl_bits", ADDR_CTRL, 32'hFFFFFFFF, 32'h1F);
    endtask
    // Round trip through encoder, serializer loop and decoder
    task automatic t_loop(input logic [4:0] mode, input string what);
        wr(ADDR_CTRL, {27'h0, mode & 5'h0F});
        half <= mode[CTL_HALF];
        wr(ADDR_CTRL, {27'h0, mode | 5'h10});
        words(60);
        rdchk("lock", ADDR_STAT, 32'h1, 32'h1);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        words(40);
        chk(what, {31'h0, good >= 30}, 32'h1);
        chk(what, bad, 32'h0);
    endtask
    task automatic t_err;
        corrupt <= 1'b1;
        words(3);
        corrupt <= 1'b0;
        rdchk("code_err", ADDR_STAT, 32'h4, 32'h4);
        // Next comma resyncs disparity, so errors stop well before the clear
        words(12);
        wr(ADDR_STAT, 32'h4);
        rdchk("cerr_clr", ADDR_STAT, 32'h4, 32'h0);
    endtask
    task automatic t_bypass;
        use_fixed <= 1'b1;
        fixed     <= {10'h155, 10'h2A5, 2'b00};
        half      <= 1'b0;
        wr(ADDR_CTRL, 32'h4);
        wait_take;
        wait_take;
        chk("byp", ser_tx_word, 32'h2A5);
        wr(ADDR_CTRL, 32'h6);
        wait_take;
        wait_take;
        chk("byp_inv", ser_tx_word, 32'h15A);
        wr(ADDR_CTRL, 32'hC);
        half <= 1'b1;
        wait_take;
        wait_take;
        chk("half_lo", ser_tx_word, 32'h2A5);
        repeat (16) @(negedge clk);
        chk("half_hi", ser_tx_word, 32'h155);
        words(4);
        chk("byp_rx_flags", {28'h0, fab_rx.k, fab_rx.err}, 32'h0);
    endtask
    task automatic t_slip;
        int o;
        @(posedge clk);
        reg_addr <= ADDR_STAT;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        o = int'(reg_rdata[7:4]);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            bitslip <= 1'b1;
            @(posedge clk);
            bitslip <= 1'b0;
            o = (o + 1) % 10;
            rdchk("slip", ADDR_STAT, 32'hF0, 32'(o) << 4);
        end
    endtask

    task automatic results;
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Whole run needs about five thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            results;
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_regs;
        t_loop(5'h10, "loop");
        t_loop(5'h13, "loop_inv");
        t_loop(5'h18, "loop_half");
        t_err;
        t_bypass;
        t_slip;
        results;
    end
endmodule // spcs_channel_tb_top

bind spcs_channel spcs_channel_asserts i_chk (.clk(clk), .arst_n(arst_n),
    .ser_rx_clk(ser_rx_clk), .ser_tx_word(ser_tx_word), .tx_clk_out(tx_clk_out),
    .rx_clk_out(rx_clk_out), .fab_rx(fab_rx), .fab_rx_valid(fab_rx_valid),
    .fab_tx_take(fab_tx_take));

`default_nettype wire
